// ===== rtl/dmc_clock_ctrl.sv
// Purpose: mic clock generator and locked loop configuration with Avalon-MM regs
// Assumes: i_mclk is the reference clock and also the system clock at 256/512 fs
// Notes:   every access takes one wait state; unmapped reads give zero
`timescale 1ns/100ps
module dmc_clock_ctrl
    import dmc_pkg::*;
(
    input  wire logic          i_mclk,
    input  wire logic          i_rst_n,
    input  wire logic          i_clk_en,
    input  wire logic [5:0]    i_avs_address,
    input  wire logic          i_avs_read,
    input  wire logic          i_avs_write,
    input  wire logic [31:0]   i_avs_writedata,
    input  wire logic [3:0]    i_avs_byteenable,
    output logic      [31:0]   o_avs_readdata,
    output logic               o_avs_waitrequest,
    output logic               o_digital_mic_clock_out,
    output logic               o_loop_run,
    output logic               o_loop_clk,
    output logic               o_loop_ref_tick,
    output logic               o_loop_ctrl_tick,
    output logic      [25:0]   o_loop_mult,
    output logic      [29:0]   o_loop_vco_mult,
    output dmc_loop_cfg_t      o_loop_cfg
);
    typedef struct packed {
        logic          ack;
        logic [15:0]   rdata;
        logic [15:0]   clock_cfg;
        logic [15:0]   ctl1;
        logic [15:0]   ctl2;
        logic [15:0]   ctl3;
        logic [15:0]   pin_func;
        logic          run;
        dmc_loop_cfg_t snap;
        logic [25:0]   mult;
        logic [29:0]   vco_mult;
        logic [2:0]    ref_cnt;
        logic          ref_tick;
        logic [2:0]    ctl_cnt;
        logic          ctl_tick;
        logic [4:0]    out_cnt;
        logic          loop_clk;
        logic [1:0]    dmic_cnt;
        logic          dmic_clk;
    } dmc_state_t;

    dmc_state_t st;
    dmc_state_t next_st;

    // byte-lane merge for a 16-bit register in the low two lanes
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
        merge16 = {be[1] ? wd[15:8] : old_v[15:8], be[0] ? wd[7:0] : old_v[7:0]};
    endfunction : merge16

    // half period of the loop output clock in mclk cycles
    function automatic logic [4:0] out_half(input logic [2:0] code);
        unique case (code)
            3'h0: out_half = 5'h01;
            3'h1: out_half = 5'h02;
            3'h2: out_half = 5'h04;
            3'h3: out_half = 5'h08;
            3'h4: out_half = 5'h10;
            3'h5: out_half = 5'h00; // 32 wraps the 5-bit count to zero
            3'h6: out_half = 5'h03;
            3'h7: out_half = 5'h06;
        endcase
    endfunction : out_half

    // ratio code to shift amount, 1XX saturates at 16
    function automatic logic [2:0] ratio_shift(input logic [2:0] code);
        ratio_shift = code[2] ? 3'h4 : {1'b0, code[1:0]};
    endfunction : ratio_shift

    logic [3:0]  idx;
    logic        req;
    logic [1:0]  dmic_half;
    logic [25:0] mult_now;
    logic        dmic_sel;

    assign idx      = i_avs_address[5:2];
    assign req      = i_avs_read | i_avs_write;
    assign dmic_sel = st.pin_func[POS_DMIC_SEL];
    // mic clock divide from system clock ratio and rate band
    always_comb begin
        unique case ({st.clock_cfg[POS_SYS_RATE],
                      st.clock_cfg[POS_SR_LO +: 4] <= SR_LAST_128FS})
            2'b11:   dmic_half = 2'h2;
            2'b10:   dmic_half = 2'h0; // four cycles wraps to zero
            2'b01:   dmic_half = 2'h1;
            default: dmic_half = 2'h2;
        endcase
    end
    // N.K as unsigned 10.16 fixed point, fraction masked in integer mode
    assign mult_now = {st.ctl3[POS_MULT_LO +: 10],
                       st.ctl1[POS_FRAC_MODE] ? st.ctl2 : 16'h0000};

    // next-state logic for bus, registers, loop and mic clock
    always_comb begin
        next_st     = st;
        next_st.ack = 1'b0;
        // one wait state per access; ack lowers waitrequest for one cycle
        if (req && !st.ack) begin
            next_st.ack = 1'b1;
            unique case (idx)
                IDX_CLOCK_CFG: next_st.rdata = st.clock_cfg;
                IDX_LOOP_CTL1: next_st.rdata = st.ctl1;
                IDX_LOOP_CTL2: next_st.rdata = st.ctl2;
                IDX_LOOP_CTL3: next_st.rdata = st.ctl3;
                IDX_STATUS:    next_st.rdata = {14'h0000, st.dmic_clk, st.run};
                IDX_PIN_FUNC:  next_st.rdata = st.pin_func;
                default:       next_st.rdata = 16'h0000;
            endcase
        end
        if (i_avs_write && st.ack) begin
            unique case (idx)
                IDX_CLOCK_CFG: next_st.clock_cfg =
                    merge16(st.clock_cfg, i_avs_writedata, i_avs_byteenable) & 16'h800F;
                IDX_LOOP_CTL1: next_st.ctl1 =
                    merge16(st.ctl1, i_avs_writedata, i_avs_byteenable) & 16'h1FFF;
                IDX_LOOP_CTL2: next_st.ctl2 =
                    merge16(st.ctl2, i_avs_writedata, i_avs_byteenable);
                IDX_LOOP_CTL3: next_st.ctl3 =
                    merge16(st.ctl3, i_avs_writedata, i_avs_byteenable) & 16'h7FEF;
                IDX_PIN_FUNC:  next_st.pin_func =
                    merge16(st.pin_func, i_avs_writedata, i_avs_byteenable) & 16'h0001;
                default: ;
            endcase
        end
        // loop: config latched on enable so live writes cannot glitch
        if (!st.ctl1[POS_ENABLE]) begin
            next_st.run      = 1'b0;
            next_st.ref_cnt  = 3'h0;
            next_st.ref_tick = 1'b0;
            next_st.ctl_cnt  = 3'h0;
            next_st.ctl_tick = 1'b0;
            next_st.out_cnt  = 5'h00;
            next_st.loop_clk = 1'b0;
        end else if (!st.run) begin
            next_st.run            = 1'b1;
            next_st.snap.prediv    = st.ctl1[POS_PREDIV_LO +: 2];
            next_st.snap.outdiv    = st.ctl1[POS_OUTDIV_LO +: 3];
            next_st.snap.rate      = st.ctl1[POS_RATE_LO +: 3];
            next_st.snap.ratio     = st.ctl1[POS_RATIO_LO +: 3];
            next_st.snap.frac_mode = st.ctl1[POS_FRAC_MODE];
            next_st.snap.gain      = st.ctl3[POS_GAIN_LO +: 4];
            next_st.mult           = mult_now;
            next_st.vco_mult       = {4'h0, mult_now} <<
                                     ratio_shift(st.ctl1[POS_RATIO_LO +: 3]);
        end else begin
            // reference is mclk divided by 1,2,4,8
            next_st.ref_tick = (st.ref_cnt == ((3'h1 << st.snap.prediv) - 3'h1));
            next_st.ref_cnt  = next_st.ref_tick ? 3'h0 : st.ref_cnt + 3'h1;
            // control block rate, code 0 ticks every cycle
            next_st.ctl_tick = (st.ctl_cnt == st.snap.rate);
            next_st.ctl_cnt  = next_st.ctl_tick ? 3'h0 : st.ctl_cnt + 3'h1;
            // output clock stand-in, mclk over the output divider
            if (st.out_cnt == out_half(st.snap.outdiv) - 5'h01) begin
                next_st.out_cnt  = 5'h00;
                next_st.loop_clk = !st.loop_clk;
            end else begin
                next_st.out_cnt  = st.out_cnt + 5'h01;
            end
        end
        // mic clock free-runs only while the pin has that function
        if (!dmic_sel) begin
            next_st.dmic_cnt = 2'h0;
            next_st.dmic_clk = 1'b0;
        end else if (st.dmic_cnt == dmic_half - 2'h1) begin
            next_st.dmic_cnt = 2'h0;
            next_st.dmic_clk = !st.dmic_clk;
        end else begin
            next_st.dmic_cnt = st.dmic_cnt + 2'h1;
        end
    end

    // single state register; clock enable freezes everything
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st           <= '0;
            st.clock_cfg <= RST_CLOCK_CFG;
            st.ctl1      <= RST_LOOP_CTL1;
            st.ctl2      <= RST_LOOP_CTL2;
            st.ctl3      <= RST_LOOP_CTL3;
            st.pin_func  <= RST_PIN_FUNC;
        end else if (i_clk_en) begin
            st <= next_st;
        end
    end

    // outputs straight from state flops, except waitrequest, which also decodes the live request
    assign o_avs_waitrequest       = req & ~st.ack;
    assign o_avs_readdata          = {16'h0000, st.rdata};
    assign o_digital_mic_clock_out = st.dmic_clk;
    assign o_loop_run              = st.run;
    assign o_loop_clk              = st.loop_clk;
    assign o_loop_ref_tick         = st.ref_tick;
    assign o_loop_ctrl_tick        = st.ctl_tick;
    assign o_loop_mult             = st.mult;
    assign o_loop_vco_mult         = st.vco_mult;
    assign o_loop_cfg              = st.snap;

    default clocking dmc_cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n || !i_clk_en);

    AST_DMIC_IDLE: assert property (!dmic_sel |=> !o_digital_mic_clock_out)
        else $error("mic clock active without pin function");
    // a rate change landing mid-half runs the count on to the new limit and a pin change clears it, so either excuses the check
    AST_DMIC_HALF2: assert property (($rose(o_digital_mic_clock_out) && dmic_sel &&
        $stable(dmic_half) && dmic_half == 2'h2) |=>
        (($changed(dmic_half) || !dmic_sel) or
         (o_digital_mic_clock_out ##1 !o_digital_mic_clock_out)))
        else $error("mic clock half period not two cycles");
    AST_CTL1_RESET: assert property ($rose(i_rst_n) |-> st.ctl1 == 16'h0102)
        else $error("loop control one reset value wrong");
    AST_MULT_RESET: assert property ($rose(i_rst_n) |->
        st.ctl2 == 16'h3127 && st.ctl3[14:5] == 10'h008)
        else $error("multiplier reset values wrong");
    AST_INT_MODE: assert property ((o_loop_run && !o_loop_cfg.frac_mode) |->
        o_loop_mult[15:0] == 16'h0000)
        else $error("fraction applied in integer mode");
    // factor written out apart from the shift function, so a broken decode shows
    AST_VCO_RATIO: assert property (o_loop_run |-> o_loop_vco_mult ==
        (o_loop_cfg.ratio[2] ? {o_loop_mult, 4'h0} :
                               ({4'h0, o_loop_mult} << o_loop_cfg.ratio[1:0])))
        else $error("oscillator multiplier does not match ratio");
    AST_STOPPED: assert property (!o_loop_run |-> !o_loop_clk && !o_loop_ref_tick)
        else $error("loop clock active while disabled");
    AST_FROZEN: assert property ((o_loop_run && $past(o_loop_run)) |->
        $stable(o_loop_mult) && $stable(o_loop_cfg))
        else $error("loop config changed while running");
    // clearing enable cuts the reference count short, so it aborts the check
    AST_REF_DIV8: assert property (
        disable iff (!i_rst_n || !i_clk_en || !st.ctl1[POS_ENABLE])
        (o_loop_ref_tick && o_loop_cfg.prediv == 2'h3) |=>
        !o_loop_ref_tick [*7] ##1 o_loop_ref_tick)
        else $error("divide by eight reference tick spacing wrong");
    AST_WAIT_ONE: assert property ((req && !st.ack) |->
        o_avs_waitrequest ##1 (!req || !o_avs_waitrequest))
        else $error("access not answered after one wait state");

    COV_LOOP_START: cover property ($rose(o_loop_run));
    COV_DMIC_TOGGLE: cover property ($rose(o_digital_mic_clock_out));
    COV_WRITE_DONE: cover property (i_avs_write && !o_avs_waitrequest);
endmodule : dmc_clock_ctrl

// ===== rtl/dmc_pkg.sv
// Purpose: constants and types for the mic clock and locked loop config block
// Assumes: registers are 16 bits wide, each on one aligned 32-bit bus word
// Notes:   register byte address is four times the register index
package dmc_pkg;
    // register indices, byte address = index * 4
    localparam logic [3:0]  IDX_CLOCK_CFG  = 4'h7;
    localparam logic [3:0]  IDX_LOOP_CTL1  = 4'h8;
    localparam logic [3:0]  IDX_LOOP_CTL2  = 4'h9;
    localparam logic [3:0]  IDX_LOOP_CTL3  = 4'hA;
    localparam logic [3:0]  IDX_STATUS     = 4'hB;
    localparam logic [3:0]  IDX_PIN_FUNC   = 4'hC;
    // reset values
    localparam logic [15:0] RST_CLOCK_CFG  = 16'h800D;
    localparam logic [15:0] RST_LOOP_CTL1  = 16'h0102;
    localparam logic [15:0] RST_LOOP_CTL2  = 16'h3127;
    localparam logic [15:0] RST_LOOP_CTL3  = 16'h0100;
    localparam logic [15:0] RST_PIN_FUNC   = 16'h0000;
    // field positions
    localparam int          POS_ENABLE     = 0;
    localparam int          POS_FRAC_MODE  = 1;
    localparam int          POS_RATIO_LO   = 2;
    localparam int          POS_RATE_LO    = 5;
    localparam int          POS_OUTDIV_LO  = 8;
    localparam int          POS_PREDIV_LO  = 11;
    localparam int          POS_MULT_LO    = 5;
    localparam int          POS_GAIN_LO    = 0;
    localparam int          POS_SR_LO      = 0;
    localparam int          POS_SYS_RATE   = 15;
    localparam int          POS_DMIC_SEL   = 0;
    localparam int          POS_ST_RUN     = 0;
    localparam int          POS_ST_DMIC    = 1;
    // sample rate codes at or below this use 128fs, above use 64fs
    localparam logic [3:0]  SR_LAST_128FS  = 4'h9;

    // configuration latched at loop enable
    typedef struct packed {
        logic [1:0] prediv;
        logic [2:0] outdiv;
        logic [2:0] rate;
        logic [2:0] ratio;
        logic       frac_mode;
        logic [3:0] gain;
    } dmc_loop_cfg_t;
endpackage : dmc_pkg

// ===== test/dmc_clock_ctrl_test.sv
// Purpose: self-checking bench for the mic clock and loop config block
// Assumes: host model drives the register bus, bench makes the clock
// Notes:   clocks and ticks are judged by counting mclk cycles at negedge
`timescale 1ns/100ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin \
    $display("unexpected %s exp %0h got %0h", n, e, s); err_total++; end end
module dmc_clock_ctrl_test
    import dmc_pkg::*;
;
    logic          i_mclk   = 1'b0;
    logic          i_rst_n  = 1'b0;
    logic          i_clk_en = 1'b1;
    logic [5:0]    adr;
    logic          rd;
    logic          wrq;
    logic [31:0]   wd;
    logic [3:0]    be;
    logic [31:0]   rdata;
    logic          wait_rq;
    logic          mic;
    logic          run;
    logic          lclk;
    logic          rtick;
    logic          ctick;
    logic [25:0]   mult;
    logic [29:0]   vco;
    dmc_loop_cfg_t cfg;
    int            err_total = 0;
    int            compares  = 0;
    int            cyc       = 0;
    int            dv[8]     = '{2, 4, 8, 16, 32, 64, 6, 12};
    int            sh[8]     = '{0, 1, 2, 3, 4, 4, 4, 4};

    dmc_host_model dmc_host_model_i (.i_mclk(i_mclk), .i_waitrequest(wait_rq),
        .i_readdata(rdata), .o_address(adr), .o_read(rd), .o_write(wrq),
        .o_writedata(wd), .o_byteenable(be));
    dmc_clock_ctrl dmc_clock_ctrl_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .i_clk_en(i_clk_en), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wrq),
        .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wait_rq), .o_digital_mic_clock_out(mic), .o_loop_run(run),
        .o_loop_clk(lclk), .o_loop_ref_tick(rtick), .o_loop_ctrl_tick(ctick),
        .o_loop_mult(mult), .o_loop_vco_mult(vco), .o_loop_cfg(cfg));

    // 50 MHz master clock
    always #10 i_mclk = ~i_mclk;

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : conclude

    // hang guard, whole run needs well under this
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_total++;
            conclude();
        end
    end

    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        logic [15:0] q;
        dmc_host_model_i.xfer(1'b1, a, d, q);
        repeat (3) @(negedge i_mclk);
    endtask : wr

    task automatic rdchk(input string n, input logic [5:0] a, input logic [15:0] e);
        logic [15:0] q;
        dmc_host_model_i.xfer(1'b0, a, 16'h0000, q);
        `CHK(n, e, q)
    endtask : rdchk

    function automatic logic pick(input int s);
        return (s == 0) ? mic : lclk;
    endfunction : pick

    // cycles between two rising edges of the chosen clock
    task automatic period(input int s, output int p);
        int n;
        n = 0;
        p = 0;
        for (int k = 0; k < 4; k++) begin
            while (pick(s) !== k[0] && n < 400) begin
                @(negedge i_mclk);
                n++;
            end
            if (k == 1) p = n;
        end
        p = n - p;
    endtask : period

    task automatic t_reset();
        rdchk("ctrl1", 6'h20, 16'h0102);
        rdchk("fraction", 6'h24, 16'h3127);
        rdchk("ctrl3", 6'h28, 16'h0100);
        rdchk("unmapped", 6'h3C, 16'h0000);
        `CHK("run", 1'b0, run)
    endtask : t_reset

    task automatic t_enable();
        int h;
        wr(6'h20, 16'h0103);
        `CHK("run", 1'b1, run)
        `CHK("mult", {10'h008, 16'h3127}, mult)
        `CHK("vco", {4'h0, 10'h008, 16'h3127}, vco)
        rdchk("status", 6'h2C, 16'h0001);
        wr(6'h20, 16'h010F);
        `CHK("ratio held", 3'h0, cfg.ratio)
        wr(6'h20, 16'h0000);
        h = 0;
        repeat (40) begin
            @(negedge i_mclk);
            h += (lclk !== 1'b0 || rtick !== 1'b0);
        end
        `CHK("run", 1'b0, run)
        `CHK("stopped", 0, h)
    endtask : t_enable

    // integer mode drops the fraction; ratio codes shift the product
    task automatic t_ratio();
        wr(6'h28, 16'h6000);
        for (int c = 0; c < 8; c++) begin
            wr(6'h20, 16'h0000);
            wr(6'h20, 16'(c * 4 + 1));
            `CHK("mult int", {10'h300, 16'h0000}, mult)
            `CHK("vco", 30'({10'h300, 16'h0000}) << sh[c], vco)
        end
    endtask : t_ratio

    // output divider codes and reference pre-divider codes
    task automatic t_div();
        int p;
        int t;
        for (int c = 0; c < 8; c++) begin
            wr(6'h20, 16'h0000);
            wr(6'h20, 16'(c * 256 + (c % 4) * 2048 + 1));
            t = 0;
            repeat (48) begin
                @(negedge i_mclk);
                t += (rtick === 1'b1);
            end
            `CHK("ref ticks", 48 >> (c % 4), t)
            period(1, p);
            `CHK("loop clk", dv[c], p)
        end
        wr(6'h20, 16'h0000);
    endtask : t_div

    // 50 MHz reference set up as software would for a 24.576 MHz output
    task automatic t_example();
        int t;
        int k;
        wr(6'h24, 16'hDD44);
        wr(6'h28, 16'h00E0);
        rdchk("ex fraction", 6'h24, 16'hDD44);
        wr(6'h20, 16'h1103);
        `CHK("ex mult", {10'h007, 16'hDD44}, mult)
        `CHK("ex vco", {4'h0, 10'h007, 16'hDD44}, vco)
        `CHK("ex prediv", 2'h2, cfg.prediv)
        `CHK("ex outdiv", 3'h1, cfg.outdiv)
        `CHK("ex ratio", 3'h0, cfg.ratio)
        `CHK("ex gain", 4'h0, cfg.gain)
        t = 0;
        k = 0;
        repeat (48) begin
            @(negedge i_mclk);
            t += (rtick === 1'b1);
            k += (ctick === 1'b1);
        end
        `CHK("ex ref ticks", 12, t)
        `CHK("ex ctrl ticks", 48, k)
        wr(6'h20, 16'h0000);
    endtask : t_example

    // mic clock per sample rate code and system clock ratio
    task automatic t_mic();
        logic [15:0] rc[4] = '{16'h800D, 16'h8003, 16'h000D, 16'h0003};
        int          ex[4] = '{8, 4, 4, 2};
        int          p;
        `CHK("mic off", 1'b0, mic)
        wr(6'h30, 16'h0001);
        for (int i = 0; i < 4; i++) begin
            wr(6'h1C, rc[i]);
            period(0, p);
            `CHK("mic period", ex[i], p)
        end
        wr(6'h30, 16'h0000);
        `CHK("mic off", 1'b0, mic)
    endtask : t_mic

    // clock enable low must hold every flop; only the running mic clock is checked
    task automatic t_freeze();
        logic m;
        int   h;
        wr(6'h30, 16'h0001);
        @(posedge i_mclk);
        i_clk_en <= 1'b0;
        @(negedge i_mclk);
        m = mic;
        h = 0;
        repeat (20) begin
            @(negedge i_mclk);
            h += (mic !== m);
        end
        @(posedge i_mclk);
        i_clk_en <= 1'b1;
        `CHK("frozen", 0, h)
        wr(6'h30, 16'h0000);
        `CHK("mic off", 1'b0, mic)
    endtask : t_freeze

    initial begin
        repeat (16) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        t_reset();
        t_enable();
        t_ratio();
        t_div();
        t_example();
        t_mic();
        t_freeze();
        conclude();
    end
endmodule : dmc_clock_ctrl_test

// ===== test/dmc_host_model.sv
// Purpose: host side model, one Avalon-MM master doing single transfers
// Assumes: slave answers through waitrequest; request held until it drops
// Notes:   byteenable stays on lanes 0-1, the only lanes the registers use
`timescale 1ns/100ps
module dmc_host_model (
    input  wire logic        i_mclk,
    input  wire logic        i_waitrequest,
    input  wire logic [31:0] i_readdata,
    output logic      [5:0]  o_address,
    output logic             o_read,
    output logic             o_write,
    output logic      [31:0] o_writedata,
    output logic      [3:0]  o_byteenable
);
    // idle bus from time zero
    initial begin
        o_address    = 6'h00;
        o_read       = 1'b0;
        o_write      = 1'b0;
        o_writedata  = 32'h00000000;
        o_byteenable = 4'h3;
    end

    // raise after an edge, hold until waitrequest is sampled low
    task automatic xfer(input logic rw, input logic [5:0] a, input logic [15:0] d,
                        output logic [15:0] q);
        @(posedge i_mclk);
        o_address   <= a;
        o_writedata <= {16'h0000, d};
        o_read      <= !rw;
        o_write     <= rw;
        // no cycle count assumed; only the bench timeout ends a stuck wait
        do begin
            @(posedge i_mclk);
        end while (i_waitrequest !== 1'b0);
        q = i_readdata[15:0];
        o_read  <= 1'b0;
        o_write <= 1'b0;
    endtask : xfer
endmodule : dmc_host_model
